// ### hw/tsd_defines.svh
`ifndef TSD_DEFINES_SVH
`define TSD_DEFINES_SVH

// ==========================================================
// Register indexes (byte address is four times the index)
`define TSD_IDX_GAIN        10'h07a
`define TSD_IDX_BANDGAP     10'h07c
`define TSD_IDX_TERM_A      10'h07e
`define TSD_IDX_TERM_B      10'h07f
`define TSD_IDX_TERM_C      10'h080
`define TSD_IDX_TERM_D      10'h081
`define TSD_IDX_SWAP_DLY    10'h09a

// ==========================================================
// Field positions and widths
`define TSD_GAIN_MSB        7
`define TSD_BANDGAP_MSB     3
`define TSD_TERM_MSB        7
`define TSD_SWAP_DLY_MSB    4

// ==========================================================
// Reset values
`define TSD_SWAP_DLY_RST    5'h08

// ==========================================================
// Swap overlap: base cycles plus twice the delay
`define TSD_OVERLAP_BASE    7'h04

`endif

// ### hw/tsd_pkg.sv
package tsd_pkg;

    typedef enum logic [0:0] {
        TSD_SWAP_IDLE    = 1'b0,
        TSD_SWAP_OVERLAP = 1'b1
    } tsd_swap_state_type;

    typedef logic [9:0] tsd_index_type;

endpackage

// ### hw/tsd_swap_timer.sv
`timescale 1ns/1ps
`include "tsd_defines.svh"

module tsd_swap_timer
    import tsd_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Control
    input  wire logic       start,
    input  wire logic [4:0] delay,
    // Status
    output logic            overlap,
    output logic            release_pulse
);

    tsd_swap_state_type state_r;
    tsd_swap_state_type state_nxt;
    logic [6:0]         cnt_r;
    logic [6:0]         cnt_nxt;
    logic               overlap_nxt;
    logic               release_nxt;
    wire logic [6:0]    load_len;
    wire logic          cnt_done;

    // ==========================================================
    // Overlap length 4 + 2*delay
    assign load_len = {1'b0, delay, 1'b0} + `TSD_OVERLAP_BASE;
    assign cnt_done = (cnt_r == 7'h00);

    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        overlap_nxt = overlap;
        release_nxt = 1'b0;
        unique case (state_r)
            TSD_SWAP_IDLE: begin
                if (start) begin
                    state_nxt   = TSD_SWAP_OVERLAP;
                    cnt_nxt     = load_len - 7'h01;
                    overlap_nxt = 1'b1;
                end
            end
            TSD_SWAP_OVERLAP: begin
                if (cnt_done) begin
                    state_nxt   = TSD_SWAP_IDLE;
                    overlap_nxt = 1'b0;
                    release_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 7'h01;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_r       <= TSD_SWAP_IDLE;
            cnt_r         <= 7'h00;
            overlap       <= 1'b0;
            release_pulse <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            cnt_r         <= cnt_nxt;
            overlap       <= overlap_nxt;
            release_pulse <= release_nxt;
        end
    end

    // ==========================================================
    // Checks
    logic [6:0] ovl_len_r;
    logic [6:0] exp_len_r;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ovl_len_r <= 7'h00;
            exp_len_r <= 7'h00;
        end else if (state_r == TSD_SWAP_IDLE && start) begin
            ovl_len_r <= 7'h00;
            exp_len_r <= load_len;
        end else if (overlap) begin
            ovl_len_r <= ovl_len_r + 7'h01;
        end
    end

    property p_overlap_len;
        @(posedge sys_clk) disable iff (!resetn)
        $fell(overlap) |-> (ovl_len_r == exp_len_r);
    endproperty
    a_overlap_len: assert property (p_overlap_len) else $error("Overlap length wrong");

    property p_release_end;
        @(posedge sys_clk) disable iff (!resetn)
        release_pulse |-> ($fell(overlap) ##1 !release_pulse);
    endproperty
    a_release_end: assert property (p_release_end) else $error("Release not at overlap end");

    property p_start_overlap;
        @(posedge sys_clk) disable iff (!resetn)
        (state_r == TSD_SWAP_IDLE && start) |=> overlap [*4];
    endproperty
    a_start_overlap: assert property (p_start_overlap) else $error("Overlap not started");

    c_swap_done: cover property (@(posedge sys_clk) disable iff (!resetn) release_pulse);

endmodule

// ### hw/tsd_regs.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "tsd_defines.svh"

module tsd_regs
    import tsd_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Factory fuse values
    input  wire logic [7:0]  fuse_gain,
    input  wire logic [3:0]  fuse_bandgap,
    input  wire logic [7:0]  fuse_term_a,
    input  wire logic [7:0]  fuse_term_b,
    input  wire logic [7:0]  fuse_term_c,
    input  wire logic [7:0]  fuse_term_d,
    // Calibration engine
    input  wire logic        cal_enable,
    input  wire logic        swap_start,
    output logic             swap_overlap,
    output logic             swap_release,
    // Trim outputs
    output logic [7:0]       core_gain_adjust_r,
    output logic [3:0]       bandgap_reference_adjust_r,
    output logic [7:0]       input_termination_adjust_a_r,
    output logic [7:0]       input_termination_adjust_b_r,
    output logic [7:0]       input_termination_adjust_c_r,
    output logic [7:0]       input_termination_adjust_d_r,
    output logic [4:0]       swap_overlap_delay_r
);

    // ==========================================================
    // Fuse synchronisers
    logic [43:0] fuse_s1_r;
    logic [43:0] fuse_s2_r;

    always_ff @(posedge sys_clk) begin
        fuse_s1_r <= {fuse_gain, fuse_bandgap, fuse_term_a, fuse_term_b, fuse_term_c, fuse_term_d};
        fuse_s2_r <= fuse_s1_r;
    end

    wire logic [7:0] fz_gain    = fuse_s2_r[43:36];
    wire logic [3:0] fz_bandgap = fuse_s2_r[35:32];
    wire logic [7:0] fz_term_a  = fuse_s2_r[31:24];
    wire logic [7:0] fz_term_b  = fuse_s2_r[23:16];
    wire logic [7:0] fz_term_c  = fuse_s2_r[15:8];
    wire logic [7:0] fz_term_d  = fuse_s2_r[7:0];

    // ==========================================================
    // APB decode
    function automatic logic hit(input logic [11:0] addr, input tsd_index_type idx);
        hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    wire logic hit_gain  = hit(paddr, `TSD_IDX_GAIN);
    wire logic hit_bg    = hit(paddr, `TSD_IDX_BANDGAP);
    wire logic hit_ta    = hit(paddr, `TSD_IDX_TERM_A);
    wire logic hit_tb    = hit(paddr, `TSD_IDX_TERM_B);
    wire logic hit_tc    = hit(paddr, `TSD_IDX_TERM_C);
    wire logic hit_td    = hit(paddr, `TSD_IDX_TERM_D);
    wire logic hit_dly   = hit(paddr, `TSD_IDX_SWAP_DLY);
    wire logic hit_any   = hit_gain | hit_bg | hit_ta | hit_tb | hit_tc | hit_td | hit_dly;
    wire logic setup_ph  = psel && !penable;
    wire logic wr_commit = psel && penable && pready && pwrite && hit_any;

    wire logic [31:0] rd_mux =
        hit_gain ? {24'h000000, core_gain_adjust_r}                        :
        hit_bg   ? {28'h0000000, bandgap_reference_adjust_r}               :
        hit_ta   ? {24'h000000, input_termination_adjust_a_r}              :
        hit_tb   ? {24'h000000, input_termination_adjust_b_r}              :
        hit_tc   ? {24'h000000, input_termination_adjust_c_r}              :
        hit_td   ? {24'h000000, input_termination_adjust_d_r}              :
        hit_dly  ? {27'h0, swap_overlap_delay_r}                           :
                   32'h00000000;

    // ==========================================================
    // APB answer: one access cycle
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph && !hit_any;
            prdata  <= (setup_ph && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // ==========================================================
    // Trim registers, fuse load at reset; swap delay loads TSD_SWAP_DLY_RST instead
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            core_gain_adjust_r           <= fz_gain;
            bandgap_reference_adjust_r   <= fz_bandgap;
            input_termination_adjust_a_r <= fz_term_a;
            input_termination_adjust_b_r <= fz_term_b;
            input_termination_adjust_c_r <= fz_term_c;
            input_termination_adjust_d_r <= fz_term_d;
            swap_overlap_delay_r         <= `TSD_SWAP_DLY_RST;
        end else if (wr_commit) begin
            if (hit_gain) begin
                core_gain_adjust_r <= pwdata[`TSD_GAIN_MSB:0];
            end
            if (hit_bg) begin
                bandgap_reference_adjust_r <= pwdata[`TSD_BANDGAP_MSB:0];
            end
            if (hit_ta) begin
                input_termination_adjust_a_r <= pwdata[`TSD_TERM_MSB:0];
            end
            if (hit_tb) begin
                input_termination_adjust_b_r <= pwdata[`TSD_TERM_MSB:0];
            end
            if (hit_tc) begin
                input_termination_adjust_c_r <= pwdata[`TSD_TERM_MSB:0];
            end
            if (hit_td) begin
                input_termination_adjust_d_r <= pwdata[`TSD_TERM_MSB:0];
            end
            if (hit_dly) begin
                swap_overlap_delay_r <= pwdata[`TSD_SWAP_DLY_MSB:0];
            end
        end
    end

    // ==========================================================
    // Background swap overlap; delay assumed stable while calibrating
    wire logic swap_go = swap_start && cal_enable;

    tsd_swap_timer u_swap_timer (
        .sys_clk       (sys_clk),
        .resetn        (resetn),
        .start         (swap_go),
        .delay         (swap_overlap_delay_r),
        .overlap       (swap_overlap),
        .release_pulse (swap_release)
    );

    // ==========================================================
    // Checks
    default clocking cb_main @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_gain_write;
        (psel && penable && pready && pwrite && hit_gain) |=> (core_gain_adjust_r == $past(pwdata[7:0]));
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("Gain trim write lost");

    property p_bg_read;
        (psel && penable && pready && !pwrite && hit_bg) |-> (prdata[31:4] == 28'h0000000)
            && (prdata[3:0] == bandgap_reference_adjust_r);
    endproperty
    a_bg_read: assert property (p_bg_read) else $error("Band-gap read wrong");

    property p_fuse_load;
        $rose(resetn) |-> (core_gain_adjust_r == $past(fz_gain))
            && (input_termination_adjust_d_r == $past(fz_term_d));
    endproperty
    a_fuse_load: assert property (p_fuse_load) else $error("Fuse value not loaded");

    property p_term_hold;
        (!wr_commit) |=> $stable(input_termination_adjust_a_r) && $stable(input_termination_adjust_c_r);
    endproperty
    a_term_hold: assert property (p_term_hold) else $error("Termination trim changed");

    property p_term_write;
        (wr_commit && hit_tb) |=> (input_termination_adjust_b_r == $past(pwdata[7:0]));
    endproperty
    a_term_write: assert property (p_term_write) else $error("Termination trim write lost");

    property p_dly_reset;
        $rose(resetn) |-> (swap_overlap_delay_r == 5'h08);
    endproperty
    a_dly_reset: assert property (p_dly_reset) else $error("Delay reset value wrong");

    property p_swap_start;
        (swap_go && !swap_overlap && !swap_release) |=> swap_overlap [*4];
    endproperty
    a_swap_start: assert property (p_swap_start) else $error("Swap overlap too short");

    property p_apb_answer;
        setup_ph |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("APB answer timing wrong");

    property p_unmapped_err;
        (setup_ph && !hit_any) |=> pready && pslverr && (prdata == 32'h00000000);
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("Unmapped access not refused");

    property p_dly_write;
        (wr_commit && hit_dly) |=> (swap_overlap_delay_r == $past(pwdata[4:0]));
    endproperty
    a_dly_write: assert property (p_dly_write) else $error("Swap delay write lost");

    property p_misalign_drop;
        (psel && penable && pready && pwrite && (paddr[1:0] != 2'b00)) |=> $stable(core_gain_adjust_r);
    endproperty
    a_misalign_drop: assert property (p_misalign_drop) else $error("Misaligned write stored");

    c_write: cover property (wr_commit && hit_dly);
    c_read: cover property (pready && !pwrite && hit_ta);
    c_unmapped: cover property (pready && pslverr);
    c_swap: cover property (swap_go ##1 swap_overlap);

endmodule

// ### verification/tsd_regs_tb.sv
`timescale 1ns/1ps
`include "tsd_defines.svh"

module trim_and_swap_delay_regs_tb_top import tsd_pkg::*;;
    logic          sys_clk;
    logic          resetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
    logic          cal_enable;
    logic          swap_start;
    logic          swap_overlap;
    logic          swap_release;
    logic [7:0]    gain;
    logic [3:0]    bgap;
    logic [7:0]    ta;
    logic [7:0]    tb;
    logic [7:0]    tc;
    logic [7:0]    td;
    logic [4:0]    dly;
    logic [7:0]    rnd;
    logic [7:0]    fz   [7];
    logic [7:0]    exp8 [7];
    logic [7:0]    msk  [7];
    tsd_index_type idx  [7];
    logic [32:0]   q    [$];
    int            fail_count;
    int            checks_done;

    tsd_regs uut (
        .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .fuse_gain(fz[0]), .fuse_bandgap(fz[1][3:0]), .fuse_term_a(fz[2]), .fuse_term_b(fz[3]),
        .fuse_term_c(fz[4]), .fuse_term_d(fz[5]), .cal_enable(cal_enable),
        .swap_start(swap_start), .swap_overlap(swap_overlap), .swap_release(swap_release),
        .core_gain_adjust_r(gain), .bandgap_reference_adjust_r(bgap),
        .input_termination_adjust_a_r(ta), .input_termination_adjust_b_r(tb),
        .input_termination_adjust_c_r(tc), .input_termination_adjust_d_r(td),
        .swap_overlap_delay_r(dly)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Helpers
    function logic [7:0] nxt();
        rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
        return rnd;
    endfunction

    task check(input logic [63:0] seen, input logic [63:0] want);
        checks_done++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, want);
        end
    endtask

    task end_sim;
        if (fail_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // APB transfer, expected {pslverr, prdata} noted for the monitor
    task apb(input logic w, input tsd_index_type i, input logic [1:0] lo, input logic [31:0] d,
             input logic [32:0] e);
        q.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, lo};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk iff pready === 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task read_all;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, idx[i], 2'b00, 32'h0, {25'h0, exp8[i]});
        end
        check({gain, bgap, ta, tb, tc, td, dly}, {exp8[0], exp8[1][3:0], exp8[2], exp8[3],
              exp8[4], exp8[5], exp8[6][4:0]});
    endtask

    task do_reset;
        resetn <= 1'b0;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
    endtask

    // Second start at k==3 falls inside the overlap and must be ignored
    task swap(input logic [4:0] d, input logic en);
        int n;
        int r;
        n = 0;
        r = 0;
        apb(1'b1, `TSD_IDX_SWAP_DLY, 2'b00, {27'h0, d}, 33'h0);
        cal_enable <= en;
        swap_start <= 1'b1;
        for (int k = 0; k < 80; k++) begin
            @(posedge sys_clk);
            swap_start <= (k == 3);
            @(negedge sys_clk);
            n += (swap_overlap === 1'b1);
            r += (swap_release === 1'b1);
        end
        check(n, en ? 4 + 2 * d : 0);
        check(r, en ? 1 : 0);
        @(posedge sys_clk);
        cal_enable <= 1'b0;
    endtask

    // ==========================================================
    // Monitor
    always @(posedge sys_clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            check({31'h0, pslverr, prdata}, {31'h0, q.pop_front()});
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        end_sim;
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] v;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        cal_enable = 1'b0;
        swap_start = 1'b0;
        fail_count = 0;
        checks_done = 0;
        rnd = 8'h61;
        idx = '{`TSD_IDX_GAIN, `TSD_IDX_BANDGAP, `TSD_IDX_TERM_A, `TSD_IDX_TERM_B,
                `TSD_IDX_TERM_C, `TSD_IDX_TERM_D, `TSD_IDX_SWAP_DLY};
        msk = '{8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f};
        for (int i = 0; i < 6; i++) begin
            fz[i] = nxt();
            exp8[i] = fz[i] & msk[i];
        end
        fz[6] = 8'h0;
        exp8[6] = 8'h08;
        do_reset;
        read_all;
        for (int i = 0; i < 7; i++) begin
            exp8[i] = nxt() & msk[i];
            apb(1'b1, idx[i], 2'b00, {24'h0, exp8[i]}, 33'h0);
        end
        read_all;
        apb(1'b0, 10'h07b, 2'b00, 32'h0, {1'b1, 32'h0});
        apb(1'b1, idx[0], 2'b10, 32'h5a, {1'b1, 32'h0});
        apb(1'b0, idx[0], 2'b01, 32'h0, {1'b1, 32'h0});
        apb(1'b0, idx[0], 2'b00, 32'h0, {25'h0, exp8[0]});
        swap(5'h00, 1'b1);
        swap(5'h07, 1'b1);
        swap(5'h1f, 1'b1);
        v = nxt();
        swap(v[4:0], 1'b1);
        swap(5'h03, 1'b0);
        do_reset;
        for (int i = 0; i < 6; i++) begin
            exp8[i] = fz[i] & msk[i];
        end
        exp8[6] = 8'h08;
        read_all;
        end_sim;
    end
endmodule
